// file: shared/sooc_pkg.sv
// package for the supply on/off and margin command block
// assumes a byte-wide command port that has already been decoded from the management bus
package sooc_pkg;

  // ==========================================================================
  // command codes of the register port
  localparam logic [7:0] CMD_RUN_STATE    = 8'h01;
  localparam logic [7:0] CMD_SWITCH_SETUP = 8'h02;

  // ==========================================================================
  // page selector values
  localparam logic [7:0] PAGE_LAST_SUPPLY = 8'h0b;
  localparam logic [7:0] PAGE_ALL         = 8'hff;

  // ==========================================================================
  // run state command byte values
  localparam logic [7:0] OP_OFF_NOW   = 8'h00;
  localparam logic [7:0] OP_OFF_NOW_A = 8'h01;
  localparam logic [7:0] OP_OFF_NOW_B = 8'h02;
  localparam logic [7:0] OP_OFF_SEQ   = 8'h40;
  localparam logic [7:0] OP_OFF_SEQ_A = 8'h41;
  localparam logic [7:0] OP_OFF_SEQ_B = 8'h42;
  localparam logic [7:0] OP_ON        = 8'h80;
  localparam logic [7:0] OP_ON_A      = 8'h81;
  localparam logic [7:0] OP_ON_B      = 8'h82;
  localparam logic [7:0] OP_MRG_LO_IG = 8'h94;
  localparam logic [7:0] OP_MRG_LO    = 8'h98;
  localparam logic [7:0] OP_MRG_HI_IG = 8'ha4;
  localparam logic [7:0] OP_MRG_HI    = 8'ha8;
  localparam logic [7:0] OP_STD_MASK  = 8'hfc;  // strips the loop select bits

  // ==========================================================================
  // supply switch setup fields
  localparam int SET_OFF_NOW  = 0;
  localparam int SET_POL_HIGH = 1;
  localparam int SET_PIN_EN   = 2;
  localparam int SET_OP_EN    = 3;
  localparam int SET_USE_CTRL = 4;
  localparam int SET_OR_SEL   = 5;
  localparam logic [7:0] SET_WR_MASK = 8'h3f;  // upper two bits read zero
  localparam logic [7:0] SET_RESET   = 8'h1e;
  localparam logic [7:0] OP_RESET    = 8'h00;

  // ==========================================================================
  // margin states
  typedef enum logic [1:0] {
    SOOC_MRG_OFF,
    SOOC_MRG_LOW,
    SOOC_MRG_HIGH
  } sooc_mrg_t;

endpackage : sooc_pkg

// file: verilog/sooc_core.sv
// supply on/off, margin state and switch pin combination for twelve supplies
// assumes command writes and reads arrive as one-cycle strobes with page already known
`timescale 1ns/1ps
module sooc_core
  import sooc_pkg::*;
#(
  parameter int NCH = 12
) (
  // clock and reset
  input  wire logic           sys_clk,
  input  wire logic           nrst,
  // command port
  input  wire logic [7:0]     page,
  input  wire logic           cmdWr,
  input  wire logic           cmdRd,
  input  wire logic [7:0]     cmdCode,
  input  wire logic [7:0]     cmdData,
  input  wire logic           faultClr,
  output logic      [7:0]     rdData,
  output logic                rdValid,
  output logic                commFault,
  output logic                alert,
  // board pins and supply status
  input  wire logic           supply_switch_pin_a,
  input  wire logic           supply_switch_pin_b,
  input  wire logic [NCH-1:0] loopB,
  input  wire logic [NCH-1:0] chanEn,
  input  wire logic [NCH-1:0] powerGood,
  // supply controls
  output logic      [NCH-1:0] supplyOn,
  output logic      [NCH-1:0] offImmediate,
  output logic      [NCH-1:0] marginLow,
  output logic      [NCH-1:0] marginHigh,
  output logic      [NCH-1:0] faultIgnore
);

  // ==========================================================================
  // decode helpers
  function automatic logic codeValid(input logic [7:0] c, input logic all);
    logic base;
    logic ext;
    base = (c == OP_OFF_NOW) || (c == OP_OFF_SEQ) || (c == OP_ON) ||
           (c == OP_MRG_LO_IG) || (c == OP_MRG_LO) ||
           (c == OP_MRG_HI_IG) || (c == OP_MRG_HI);
    ext  = (c == OP_OFF_NOW_A) || (c == OP_OFF_NOW_B) || (c == OP_OFF_SEQ_A) ||
           (c == OP_OFF_SEQ_B) || (c == OP_ON_A) || (c == OP_ON_B);
    return base || (all && ext);
  endfunction : codeValid

  function automatic logic [NCH-1:0] targetMask(input logic [7:0] pg, input logic [7:0] c,
                                               input logic [NCH-1:0] lb);
    logic [NCH-1:0] m;
    m = '0;
    if (pg <= PAGE_LAST_SUPPLY) begin
      m[pg[3:0]] = 1'b1;  // one supply only
    end else if (pg == PAGE_ALL) begin
      // low two bits pick the loop; margin codes keep them zero and reach all
      case (c[1:0])
        2'b01:   m = ~lb;
        2'b10:   m = lb;
        default: m = '1;
      endcase
    end
    return m;
  endfunction : targetMask

  // ==========================================================================
  // registers and internal state
  logic [7:0]     setup_ff;
  logic [7:0]     opByte_ff;
  logic [NCH-1:0] cmdOn_ff;
  logic [NCH-1:0] cmdImm_ff;
  sooc_mrg_t      mrgMode_ff [NCH];
  logic [NCH-1:0] mrgIgn_ff;
  logic [1:0]     pinMeta_ff;
  logic [1:0]     pinSync_ff;
  logic [NCH-1:0] supplyOn_ff;
  logic [NCH-1:0] offImm_ff;
  logic [NCH-1:0] mrgLo_ff;
  logic [NCH-1:0] mrgHi_ff;
  logic [NCH-1:0] fltIgn_ff;
  logic [7:0]     rdData_ff;
  logic           rdValid_ff;
  logic           commFault_ff;
  logic           alert_ff;

  logic           isOpWr;
  logic           isAll;
  logic           isSupplyPage;
  logic           opValid;
  logic           opEn;
  logic           pinEn;
  logic [NCH-1:0] wrMask;
  logic [NCH-1:0] mrgMask;
  logic [1:0]     pinOnLoop;
  logic [NCH-1:0] pinOn;
  logic [NCH-1:0] nxt_supplyOn;
  logic [NCH-1:0] nxt_offImm;
  logic           allGood;

  assign isOpWr       = cmdWr && (cmdCode == CMD_RUN_STATE);
  assign isAll        = (page == PAGE_ALL);
  assign isSupplyPage = (page <= PAGE_LAST_SUPPLY) || isAll;
  assign opValid      = isSupplyPage && codeValid(cmdData, isAll);
  assign opEn         = setup_ff[SET_OP_EN];
  assign pinEn        = setup_ff[SET_PIN_EN];
  assign wrMask       = targetMask(page, cmdData, loopB);
  // without the on/off path a margin code only reaches supplies that are on
  assign mrgMask      = opEn ? wrMask : (wrMask & supplyOn_ff);
  assign allGood      = &(powerGood | ~chanEn);

  // ==========================================================================
  // switch pin synchronisers, one per sequence loop
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pinMeta_ff <= 2'b00;
      pinSync_ff <= 2'b00;
    end else begin
      pinMeta_ff <= {supply_switch_pin_b, supply_switch_pin_a};
      pinSync_ff <= pinMeta_ff;
    end
  end

  // same polarity setting for both pins
  assign pinOnLoop = setup_ff[SET_POL_HIGH] ? pinSync_ff : ~pinSync_ff;
  assign pinOn     = (loopB & {NCH{pinOnLoop[1]}}) | (~loopB & {NCH{pinOnLoop[0]}});

  // ==========================================================================
  // setup and run state bytes
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      setup_ff  <= SET_RESET;
      opByte_ff <= OP_RESET;
    end else if (cmdWr && (cmdCode == CMD_SWITCH_SETUP)) begin
      // changing this while supplies run takes effect at once; host must avoid it
      setup_ff <= cmdData & SET_WR_MASK;
    end else if (isOpWr && opValid) begin
      opByte_ff <= cmdData & OP_STD_MASK;
    end
  end

  // ==========================================================================
  // command on/off state per supply
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cmdOn_ff  <= '0;
      cmdImm_ff <= '0;
    end else if (isOpWr && opValid && opEn) begin
      for (int i = 0; i < NCH; i++) begin
        if (wrMask[i]) begin
          cmdOn_ff[i]  <= cmdData[7];
          cmdImm_ff[i] <= (cmdData[7:6] == 2'b00);
        end
      end
    end
  end

  // ==========================================================================
  // margin state per supply, applied regardless of the on/off enable
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < NCH; i++) begin
        mrgMode_ff[i] <= SOOC_MRG_OFF;
      end
      mrgIgn_ff <= '0;
    end else if (isOpWr && opValid && cmdData[7]) begin
      for (int i = 0; i < NCH; i++) begin
        if (mrgMask[i]) begin
          case (cmdData[5:4])
            2'b01:   mrgMode_ff[i] <= SOOC_MRG_LOW;
            2'b10:   mrgMode_ff[i] <= SOOC_MRG_HIGH;
            default: mrgMode_ff[i] <= SOOC_MRG_OFF;
          endcase
          mrgIgn_ff[i] <= (cmdData[3:2] == 2'b01);
        end
      end
    end
  end

  // ==========================================================================
  // on/off combination of pin and command paths
  always_comb begin
    nxt_supplyOn = '0;
    nxt_offImm   = offImm_ff;
    for (int i = 0; i < NCH; i++) begin
      // bit 4 set with neither path enabled leaves the supply off
      if (!setup_ff[SET_USE_CTRL]) begin
        nxt_supplyOn[i] = 1'b1;
      end else if (opEn && pinEn) begin
        nxt_supplyOn[i] = setup_ff[SET_OR_SEL] ? (cmdOn_ff[i] || pinOn[i])
                                               : (cmdOn_ff[i] && pinOn[i]);
      end else if (pinEn) begin
        nxt_supplyOn[i] = pinOn[i];
      end else if (opEn) begin
        nxt_supplyOn[i] = cmdOn_ff[i];
      end
      // either path asking off with its immediate flavour cuts at once
      if (supplyOn_ff[i] && !nxt_supplyOn[i]) begin
        nxt_offImm[i] = (pinEn && !pinOn[i] && setup_ff[SET_OFF_NOW]) ||
                        (opEn && !cmdOn_ff[i] && cmdImm_ff[i]);
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      supplyOn_ff <= '0;
      offImm_ff   <= '0;
    end else begin
      supplyOn_ff <= nxt_supplyOn;
      offImm_ff   <= nxt_offImm;
    end
  end

  // ==========================================================================
  // margin outputs held off until every enabled supply is good
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      mrgLo_ff  <= '0;
      mrgHi_ff  <= '0;
      fltIgn_ff <= '0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        mrgLo_ff[i]  <= allGood && supplyOn_ff[i] && (mrgMode_ff[i] == SOOC_MRG_LOW);
        mrgHi_ff[i]  <= allGood && supplyOn_ff[i] && (mrgMode_ff[i] == SOOC_MRG_HIGH);
        fltIgn_ff[i] <= allGood && supplyOn_ff[i] && mrgIgn_ff[i] &&
                        (mrgMode_ff[i] != SOOC_MRG_OFF);
      end
    end
  end

  // ==========================================================================
  // readback and communication fault; a new fault wins over a clear
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rdData_ff  <= 8'h00;
      rdValid_ff <= 1'b0;
    end else begin
      // other codes read zero so a stale byte is never taken for data
      rdValid_ff <= cmdRd;
      if (cmdRd) begin
        case (cmdCode)
          CMD_RUN_STATE:    rdData_ff <= opByte_ff;
          CMD_SWITCH_SETUP: rdData_ff <= setup_ff;
          default:          rdData_ff <= 8'h00;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      commFault_ff <= 1'b0;
      alert_ff     <= 1'b0;
    end else if (isOpWr && !opValid) begin
      commFault_ff <= 1'b1;
      alert_ff     <= 1'b1;
    end else if (faultClr) begin
      commFault_ff <= 1'b0;
      alert_ff     <= 1'b0;
    end
  end

  assign rdData       = rdData_ff;
  assign rdValid      = rdValid_ff;
  assign commFault    = commFault_ff;
  assign alert        = alert_ff;
  assign supplyOn     = supplyOn_ff;
  assign offImmediate = offImm_ff;
  assign marginLow    = mrgLo_ff;
  assign marginHigh   = mrgHi_ff;
  assign faultIgnore  = fltIgn_ff;

  // ==========================================================================
  // assertions
  a_bad_code_flags: assert property (@(posedge sys_clk) disable iff (!nrst)
    (isOpWr && !opValid) |=> (commFault && alert))
    else $error("invalid run state code did not raise fault");
  a_margin_needs_good: assert property (@(posedge sys_clk) disable iff (!nrst)
    (marginLow | marginHigh) != '0 |-> $past(allGood))
    else $error("margin began before supplies were good");
  a_bias_turns_on: assert property (@(posedge sys_clk) disable iff (!nrst)
    !setup_ff[SET_USE_CTRL] |=> (supplyOn == '1))
    else $error("supplies not on with bias only setup");
  a_op_off_gated: assert property (@(posedge sys_clk) disable iff (!nrst)
    (isOpWr && !opEn) |=> $stable(cmdOn_ff))
    else $error("on/off applied while operation disabled");
  a_page_only_one: assert property (@(posedge sys_clk) disable iff (!nrst)
    (isOpWr && opValid && opEn && page == 8'h03) |=> $stable(cmdOn_ff[2]))
    else $error("single page write touched another supply");
  a_readback_std: assert property (@(posedge sys_clk) disable iff (!nrst)
    (isOpWr && opValid && (cmdData == OP_ON_B)) |=> (opByte_ff == OP_ON))
    else $error("readback kept extended code");
  a_and_mode: assert property (@(posedge sys_clk) disable iff (!nrst)
    (setup_ff[5:2] == 4'b0111 && !cmdOn_ff[0]) |=> !supplyOn[0])
    else $error("and mode turned on without command");
  a_pin_off_now: assert property (@(posedge sys_clk) disable iff (!nrst)
    (setup_ff[5:0] == 6'b010101 && supplyOn_ff[0] && !pinOn[0]) |=> offImmediate[0])
    else $error("pin off not immediate with bit 0 set");
  a_loop_a_only: assert property (@(posedge sys_clk) disable iff (!nrst)
    (isOpWr && opValid && opEn && isAll && (cmdData == OP_ON_A)) |=>
      $stable(cmdOn_ff & loopB))
    else $error("loop a code changed a loop b supply");
  a_margin_sets_on: assert property (@(posedge sys_clk) disable iff (!nrst)
    (isOpWr && opValid && opEn && (cmdData == OP_MRG_HI)) |=>
      ((cmdOn_ff & $past(wrMask)) == $past(wrMask)))
    else $error("margin code left a targeted supply off");
  a_cmd_off_now: assert property (@(posedge sys_clk) disable iff (!nrst)
    ((setup_ff[5:2] == 4'h6) && supplyOn_ff[3] && !cmdOn_ff[3] && cmdImm_ff[3]) |=>
      offImmediate[3])
    else $error("command immediate off was not immediate");
  a_ext_code_paged: assert property (@(posedge sys_clk) disable iff (!nrst)
    (isOpWr && !isAll && (cmdData == OP_OFF_NOW_A)) |=> (commFault && alert))
    else $error("loop code on a single page was not refused");

  // ==========================================================================
  // covers for the main scenarios
  c_margin_high: cover property (@(posedge sys_clk) disable iff (!nrst) marginHigh[0]);
  c_cmd_off_now: cover property (@(posedge sys_clk) disable iff (!nrst) offImmediate[3]);
  c_bad_code: cover property (@(posedge sys_clk) disable iff (!nrst) (isOpWr && !opValid));
  c_or_mode_on: cover property (@(posedge sys_clk) disable iff (!nrst)
    (setup_ff[SET_OR_SEL] && supplyOn[0]));

endmodule : sooc_core

// file: dv/sooc_host_model.sv
// host and switch pin model facing the supply on/off block
// assumes the bench calls its tasks at a falling clock edge
`timescale 1ns/1ps
module sooc_host_model (
  // clock
  input  wire logic       sys_clk,
  // command port
  output logic      [7:0] page,
  output logic            cmdWr,
  output logic            cmdRd,
  output logic      [7:0] cmdCode,
  output logic      [7:0] cmdData,
  output logic            faultClr,
  input  wire logic [7:0] rdData,
  input  wire logic       rdValid,
  // switch pins of loop a and loop b
  output logic            supply_switch_pin_a,
  output logic            supply_switch_pin_b
);
  // ==========================================================================
  // idle levels: pins low request off under the reset polarity
  initial begin
    page                = 8'h00;
    cmdWr               = 1'b0;
    cmdRd               = 1'b0;
    cmdCode             = 8'h00;
    cmdData             = 8'h00;
    faultClr            = 1'b0;
    supply_switch_pin_a = 1'b0;
    supply_switch_pin_b = 1'b0;
  end

  // ==========================================================================
  // one write; spare edge after it so strobes never toggle in one step
  task automatic wr(input logic [7:0] pg, input logic [7:0] code, input logic [7:0] d);
    page    = pg;
    cmdCode = code;
    cmdData = d;
    cmdWr   = 1'b1;
    @(negedge sys_clk);
    cmdWr   = 1'b0;
    cmdCode = ~code;
    cmdData = ~d;  // released byte must not keep its value
    @(negedge sys_clk);
  endtask : wr

  // one read, bounded wait for the valid pulse
  task automatic rd(input logic [7:0] code, output logic [7:0] d, output logic ok);
    int n;
    cmdCode = code;
    cmdRd   = 1'b1;
    @(negedge sys_clk);
    cmdRd   = 1'b0;
    cmdCode = ~code;
    n = 0;
    while (rdValid !== 1'b1 && n < 4) begin
      @(negedge sys_clk);
      n++;
    end
    ok = (rdValid === 1'b1);
    d  = rdData;
    @(negedge sys_clk);
  endtask : rd

  // fault clear pulse
  task automatic clr();
    faultClr = 1'b1;
    @(negedge sys_clk);
    faultClr = 1'b0;
    @(negedge sys_clk);
  endtask : clr

  // board logic moves both switch pins
  task automatic pins(input logic a, input logic b);
    supply_switch_pin_a = a;
    supply_switch_pin_b = b;
  endtask : pins
endmodule : sooc_host_model

// file: dv/supply_on_off_margin_control_tb_top.sv
// self-checking bench for the supply on/off and margin block
// assumes loop b holds channels 8 to 11, host model drives the command port
`timescale 1ns/1ps
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin mismatches++; \
  $display("unexpected at %0t: got %h want %h", $time, (got), (exp)); end end
module supply_on_off_margin_control_tb_top;
  import sooc_pkg::*;
  localparam logic [11:0] LA = 12'h0ff;
  localparam logic [11:0] LB = 12'hf00;
  localparam logic [7:0] MC [4] = '{8'h94, 8'h98, 8'ha4, 8'ha8};
  localparam logic [3:0] MX [4] = '{4'b1101, 4'b1100, 4'b1011, 4'b1010};
  localparam logic [7:0] EC [11] = '{8'h80, 8'h01, 8'h81, 8'h02, 8'h82, 8'h41,
                                     8'h00, 8'h82, 8'h81, 8'h42, 8'h40};
  localparam logic [11:0] EO [11] = '{12'hfff, LB, 12'hfff, LA, 12'hfff, LB,
                                      12'h000, LB, 12'hfff, LA, 12'h000};
  localparam logic [7:0] ER [11] = '{8'h80, 8'h00, 8'h80, 8'h00, 8'h80, 8'h40,
                                     8'h00, 8'h80, 8'h80, 8'h40, 8'h40};
  // ==========================================================================
  // nets
  logic        sys_clk, nrst, cmdWr, cmdRd, faultClr, rdValid, commFault, alert;
  logic        supply_switch_pin_a, supply_switch_pin_b, ok;
  logic [7:0]  page, cmdCode, cmdData, rdData, d;
  logic [11:0] chanEn, powerGood, supplyOn, offImmediate, marginLow, marginHigh;
  logic [11:0] faultIgnore;
  int          mismatches = 0;
  int          checks = 0;

  // clock and design under test
  initial sys_clk = 1'b0;
  always #50 sys_clk = ~sys_clk;
  sooc_core i_sooc_core (.sys_clk, .nrst, .page, .cmdWr, .cmdRd, .cmdCode, .cmdData,
    .faultClr, .rdData, .rdValid, .commFault, .alert, .supply_switch_pin_a,
    .supply_switch_pin_b, .loopB(LB), .chanEn, .powerGood, .supplyOn, .offImmediate,
    .marginLow, .marginHigh, .faultIgnore);
  sooc_host_model i_host (.sys_clk, .page, .cmdWr, .cmdRd, .cmdCode, .cmdData,
    .faultClr, .rdData, .rdValid, .supply_switch_pin_a, .supply_switch_pin_b);

  // ==========================================================================
  // helpers
  task automatic wt(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : wt
  // fresh reset so setup only changes while supplies are off
  task automatic start(input logic [7:0] s);
    nrst = 1'b0;
    wt(3);
    nrst = 1'b1;
    wt(1);
    i_host.wr(8'h00, CMD_SWITCH_SETUP, s);
  endtask : start

  // ==========================================================================
  // scenarios
  task automatic t_single();
    start(8'h18);
    i_host.wr(8'h03, CMD_RUN_STATE, OP_ON);
    wt(4);
    `CHK(supplyOn, 12'h008)
    i_host.wr(8'h03, CMD_RUN_STATE, OP_OFF_SEQ);
    wt(4);
    `CHK({supplyOn[3], offImmediate[3]}, 2'b00)
    i_host.wr(8'h05, CMD_RUN_STATE, OP_ON);
    i_host.wr(8'h03, CMD_RUN_STATE, OP_ON);
    i_host.wr(8'h03, CMD_RUN_STATE, OP_OFF_NOW);
    wt(4);
    `CHK({supplyOn, offImmediate}, {12'h020, 12'h008})
  endtask : t_single

  task automatic t_margin();
    start(8'h18);
    powerGood = 12'hfdf;
    i_host.wr(8'h03, CMD_RUN_STATE, OP_MRG_LO_IG);
    wt(4);
    `CHK({supplyOn[3], marginLow}, {1'b1, 12'h000})
    powerGood = 12'hfff;
    wt(4);
    `CHK({marginLow, faultIgnore}, {12'h008, 12'h008})
    for (int i = 0; i < 4; i++) begin
      i_host.wr(8'h03, CMD_RUN_STATE, MC[i]);
      wt(4);
      `CHK({supplyOn[3], marginLow[3], marginHigh[3], faultIgnore[3]}, MX[i])
      `CHK(faultIgnore[3], ~MC[i][3])
    end
    // a disabled channel that is not good must not hold margining back
    chanEn    = 12'hfdf;
    powerGood = 12'hfdf;
    wt(3);
    `CHK(marginHigh, 12'h008)
    chanEn    = 12'hfff;
    powerGood = 12'hfff;
  endtask : t_margin

  task automatic t_all();
    start(8'h18);
    for (int i = 0; i < 11; i++) begin
      i_host.wr(PAGE_ALL, CMD_RUN_STATE, EC[i]);
      wt(3);
      `CHK(supplyOn, EO[i])
      i_host.rd(CMD_RUN_STATE, d, ok);
      `CHK({ok, d}, {1'b1, ER[i]})
    end
    i_host.wr(PAGE_ALL, CMD_RUN_STATE, OP_MRG_HI);
    wt(4);
    `CHK({supplyOn, marginHigh}, {12'hfff, 12'hfff})
  endtask : t_all

  task automatic t_pins();
    start(8'h12);
    i_host.pins(1'b1, 1'b1);
    wt(5);
    `CHK(supplyOn, 12'h000)
    start(8'h15);
    i_host.pins(1'b0, 1'b1);
    wt(1);
    `CHK(supplyOn, 12'h000)
    wt(4);
    `CHK(supplyOn, LA)
    i_host.pins(1'b1, 1'b0);
    wt(5);
    `CHK({supplyOn, offImmediate & LA}, {LB, LA})
    i_host.wr(PAGE_ALL, CMD_RUN_STATE, OP_OFF_NOW);
    i_host.wr(PAGE_ALL, CMD_RUN_STATE, OP_MRG_LO);
    wt(4);
    `CHK(supplyOn, LB)
    `CHK(marginLow, LB)
    start(8'h16);
    i_host.pins(1'b1, 1'b1);
    wt(5);
    i_host.wr(PAGE_ALL, CMD_RUN_STATE, OP_MRG_HI_IG);
    wt(4);
    `CHK(marginHigh, 12'hfff)
    i_host.pins(1'b0, 1'b1);
    wt(5);
    `CHK(supplyOn, LB)
    i_host.pins(1'b0, 1'b0);
    wt(5);
    `CHK({supplyOn, offImmediate}, 24'h000000)
  endtask : t_pins

  task automatic t_combine();
    i_host.pins(1'b1, 1'b1);
    start(8'h1e);
    wt(5);
    `CHK(supplyOn, 12'h000)
    i_host.wr(PAGE_ALL, CMD_RUN_STATE, OP_ON);
    wt(4);
    `CHK(supplyOn, 12'hfff)
    i_host.pins(1'b0, 1'b1);
    wt(5);
    `CHK(supplyOn, LB)
    i_host.pins(1'b1, 1'b0);
    start(8'h3e);
    wt(5);
    `CHK(supplyOn, LA)
    i_host.wr(PAGE_ALL, CMD_RUN_STATE, OP_ON);
    wt(4);
    `CHK(supplyOn, 12'hfff)
    i_host.pins(1'b1, 1'b1);
    start(8'h00);
    wt(4);
    `CHK(supplyOn, 12'hfff)
  endtask : t_combine

  task automatic t_fault();
    i_host.pins(1'b0, 1'b0);
    start(8'hff);
    i_host.rd(CMD_SWITCH_SETUP, d, ok);
    `CHK({ok, d}, {1'b1, 8'h3f})
    i_host.wr(8'h03, CMD_RUN_STATE, OP_ON);
    i_host.wr(8'h03, CMD_RUN_STATE, 8'h55);
    `CHK({commFault, alert}, 2'b11)
    i_host.rd(CMD_RUN_STATE, d, ok);
    `CHK(d, OP_ON)
    i_host.clr();
    `CHK({commFault, alert}, 2'b00)
    i_host.wr(8'h03, CMD_RUN_STATE, OP_OFF_NOW_A);
    i_host.wr(8'h0c, CMD_RUN_STATE, OP_OFF_NOW);
    wt(4);
    `CHK({commFault, alert, supplyOn}, {2'b11, 12'h008})
  endtask : t_fault

  // ==========================================================================
  // verdict
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : complete_run

  initial begin
    repeat (20000) @(posedge sys_clk);
    mismatches++;
    complete_run();
  end

  // main sequence, reset values read first
  initial begin
    nrst      = 1'b0;
    chanEn    = 12'hfff;
    powerGood = 12'hfff;
    wt(3);
    nrst = 1'b1;
    wt(1);
    `CHK({supplyOn, marginLow, commFault}, 25'h0)
    i_host.rd(CMD_RUN_STATE, d, ok);
    `CHK({ok, d}, {1'b1, OP_RESET})
    i_host.rd(CMD_SWITCH_SETUP, d, ok);
    `CHK({ok, d}, {1'b1, SET_RESET})
    t_single();
    t_margin();
    t_all();
    t_pins();
    t_combine();
    t_fault();
    complete_run();
  end
endmodule : supply_on_off_margin_control_tb_top
